// >>> core/ese_ctrl.sv
// Purpose: Extended-state enable mask, enable flag and instruction gating
// Assumes: Requests come from logic on clk; answer one cycle later
// Notes:   Capability bitmap and save support are build parameters
`timescale 1ns/10ps
module ese_ctrl
    import ese_pkg::*;
#(
    parameter logic [63:0] USER_CAP_MAP   = ESE_CAP_DEFAULT,
    parameter logic        SAVE_SUPPORTED = 1'b1
)
(
    input  wire logic           clk,
    input  wire logic           sys_rst,
    input  wire ese_req_type    req,
    output ese_rsp_type         rsp,
    output ese_family_type      fam,
    output logic [63:0]         mask_value
);

    typedef struct packed
    {
        logic [63:0]    mask;
        ese_rsp_type    rsp;
        ese_family_type fam;
    } ese_state_type;

    ese_state_type state_ff;
    ese_state_type nxt_state;

    logic [63:0] src;
    logic        write_bad;
    logic        flag;
    logic        ring0;
    logic        sel0;

    assign src   = {req.high_src, req.low_src};
    assign flag  = state_ff.fam.save_feature_enable_flag;
    assign ring0 = (req.priv_lvl == 2'b00);
    assign sel0  = (req.selector == ESE_SEL_MASK);

    // All value checks in parallel, so no partial update can happen
    always_comb
    begin
        write_bad = 1'b0;
        if (!src[ESE_LEGACY_BIT])
            write_bad = 1'b1;
        if (src[ESE_WIDE_BIT] && !src[ESE_BASIC_BIT])
            write_bad = 1'b1;
        if (src[ESE_BOUNDS_HI] != src[ESE_BOUNDS_LO])
            write_bad = 1'b1;
        if ((src[ESE_EXT_HI:ESE_EXT_LO] != 3'b000)
            && !(&{src[ESE_EXT_HI:ESE_EXT_LO], src[ESE_WIDE_BIT:1]}))
            write_bad = 1'b1;
        if (src[ESE_TILE_CFG_BIT] != src[ESE_TILE_DATA_BIT])
            write_bad = 1'b1;
        if ((src & ESE_RSVD_BITS) != 64'h0000_0000_0000_0000)
            write_bad = 1'b1;
        // Covers bits 2, 4:3, 7:5, 9 and 18:17 capability gating
        if ((src & ~USER_CAP_MAP) != 64'h0000_0000_0000_0000)
            write_bad = 1'b1;
    end

    // Next state: answer one request, then refresh family gates
    always_comb
    begin
        nxt_state           = state_ff;
        nxt_state.rsp       = '0;
        nxt_state.rsp.valid = req.valid && (req.op != ESE_OP_NONE);
        if (req.valid)
        begin
            unique case (req.op)
                ESE_OP_NONE:
                begin
                    nxt_state.rsp.valid = 1'b0;
                end
                ESE_OP_WR_CTRL4:
                begin
                    // Only the enable flag lives here
                    if (!ring0)
                        nxt_state.rsp.gp = 1'b1;
                    else if (src[ESE_FLAG_BIT] && !SAVE_SUPPORTED)
                        nxt_state.rsp.gp = 1'b1;
                    else
                        nxt_state.fam.save_feature_enable_flag =
                            src[ESE_FLAG_BIT];
                end
                ESE_OP_RD_CTRL4:
                begin
                    if (!ring0)
                        nxt_state.rsp.gp = 1'b1;
                    else
                        nxt_state.rsp.data[ESE_FLAG_BIT] = flag;
                end
                ESE_OP_WR_XCR:
                begin
                    if (!flag)
                        nxt_state.rsp.ud = 1'b1;
                    else if (!ring0)
                        nxt_state.rsp.gp = 1'b1;
                    else if (!sel0 || write_bad)
                        nxt_state.rsp.gp = 1'b1;
                    else
                        nxt_state.mask = src;
                end
                ESE_OP_RD_XCR:
                begin
                    // No privilege check on purpose
                    if (!flag)
                        nxt_state.rsp.ud = 1'b1;
                    else if (!sel0)
                        nxt_state.rsp.gp = 1'b1;
                    else
                        nxt_state.rsp.data = state_ff.mask;
                end
                ESE_OP_SAVE_RST:
                begin
                    // Tile state is saved in any mode
                    nxt_state.rsp.ud = !flag;
                end
                ESE_OP_IDENT1:
                begin
                    nxt_state.rsp.data[ESE_ID_FLAG_BIT] = flag;
                    nxt_state.rsp.data[ESE_ID_SUPP_BIT] = SAVE_SUPPORTED;
                end
                ESE_OP_WIDE_VEC:
                begin
                    nxt_state.rsp.ud = !state_ff.fam.wide_vec_ok;
                end
                ESE_OP_EXT_VEC:
                begin
                    nxt_state.rsp.ud = !state_ff.fam.ext_vec_ok;
                end
                ESE_OP_TILE:
                begin
                    nxt_state.rsp.ud = !state_ff.fam.tile_ok
                                       || !req.long_mode;
                end
                ESE_OP_BOUNDS:
                begin
                    nxt_state.rsp.nop = !state_ff.fam.bounds_active;
                end
                ESE_OP_BASIC, ESE_OP_PKEY:
                begin
                    // Never gated by mask bits 1 or 9
                    nxt_state.rsp.ud = 1'b0;
                end
                default:
                begin
                    nxt_state.rsp.valid = 1'b0;
                end
            endcase
        end
        // Gates follow the next mask; cleared fields leave state alone
        nxt_state.fam.wide_vec_ok = nxt_state.fam.save_feature_enable_flag
            && nxt_state.mask[ESE_WIDE_BIT];
        nxt_state.fam.ext_vec_ok = nxt_state.fam.save_feature_enable_flag
            && (&nxt_state.mask[ESE_EXT_HI:ESE_EXT_LO]);
        nxt_state.fam.tile_ok = nxt_state.fam.save_feature_enable_flag
            && nxt_state.mask[ESE_TILE_CFG_BIT]
            && nxt_state.mask[ESE_TILE_DATA_BIT];
        nxt_state.fam.bounds_active =
            nxt_state.fam.save_feature_enable_flag
            && nxt_state.mask[ESE_BOUNDS_HI]
            && nxt_state.mask[ESE_BOUNDS_LO];
    end

    // State register; mask wakes with only the legacy bit set
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state_ff      <= '0;
            state_ff.mask <= ESE_MASK_RESET;
        end
        else
        begin
            state_ff <= nxt_state;
        end
    end

    assign rsp        = state_ff.rsp;
    assign fam        = state_ff.fam;
    assign mask_value = state_ff.mask;

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    chk_legacy_bit_one: assert property (mask_value[0])
        else $error("Legacy state bit read as zero");
    chk_wr_good_load: assert property (
        req.valid && req.op == ESE_OP_WR_XCR && flag && ring0 && sel0
        && !write_bad |=> mask_value == $past(src) && !rsp.gp)
        else $error("Valid mask write did not load");
    chk_wr_ring_gp: assert property (
        req.valid && req.op == ESE_OP_WR_XCR && flag && !ring0
        |=> rsp.gp && $stable(mask_value))
        else $error("Unprivileged mask write not refused");
    chk_flag_off_ud: assert property (
        req.valid && !flag && (req.op == ESE_OP_WR_XCR
        || req.op == ESE_OP_RD_XCR || req.op == ESE_OP_SAVE_RST)
        |=> rsp.valid && rsp.ud)
        else $error("Disabled save instruction did not fault");
    chk_bad_no_update: assert property (
        req.valid && req.op == ESE_OP_WR_XCR && write_bad
        |=> $stable(mask_value))
        else $error("Faulting write changed the mask");
    chk_pair_fields: assert property (
        (mask_value[4] == mask_value[3])
        && (mask_value[7:5] == 3'b000 || mask_value[7:5] == 3'b111)
        && (mask_value[18] == mask_value[17])
        && !(mask_value[2] && !mask_value[1]))
        else $error("Mask holds an illegal field pairing");
    chk_rsvd_zero: assert property (
        (mask_value & (ESE_RSVD_BITS | ~USER_CAP_MAP))
        == 64'h0000_0000_0000_0000)
        else $error("Reserved or unsupported mask bit set");
    chk_rd_ctrl_gp: assert property (
        req.valid && req.op == ESE_OP_RD_CTRL4 && !ring0
        |=> rsp.gp && rsp.data == 64'h0000_0000_0000_0000)
        else $error("Unprivileged control read not refused");
    chk_ident_flag: assert property (
        req.valid && req.op == ESE_OP_IDENT1
        |=> rsp.data[ESE_ID_FLAG_BIT] == fam.save_feature_enable_flag)
        else $error("Identification flag bit wrong");
    chk_rd_mask_any: assert property (
        req.valid && req.op == ESE_OP_RD_XCR && flag && sel0
        |=> !rsp.gp && !rsp.ud && rsp.data == $past(mask_value))
        else $error("Mask read result wrong");
    chk_tile_gate: assert property (
        req.valid && req.op == ESE_OP_TILE
        |=> rsp.ud == !($past(fam.tile_ok) && $past(req.long_mode)))
        else $error("Tile gating wrong");
    chk_ext_gate: assert property (
        fam.ext_vec_ok == (fam.save_feature_enable_flag
        && mask_value[7:5] == 3'b111))
        else $error("Extended vector gate mismatch");
    chk_bounds_nop: assert property (
        req.valid && req.op == ESE_OP_BOUNDS
        |=> rsp.nop == !$past(fam.bounds_active) && !rsp.ud)
        else $error("Bounds no-op gating wrong");
    chk_flag_support: assert property (
        !SAVE_SUPPORTED |-> !fam.save_feature_enable_flag)
        else $error("Flag set without save support");

    // Shorthand antecedents: a gated mask write reaches the value
    // checks, so each value rule must end in its own refusal
    logic wr_gated;
    logic op_taken;

    assign wr_gated = req.valid && (req.op == ESE_OP_WR_XCR) && flag
                      && ring0 && sel0;
    assign op_taken = req.valid && (req.op != ESE_OP_NONE)
                      && (req.op <= ESE_OP_PKEY);

    // Answer is a one-cycle pulse; quiet cycles carry all zeros
    chk_rsp_pulse: assert property (
        op_taken |=> rsp.valid)
        else $error("Request got no answer");

    chk_rsp_quiet: assert property (
        !op_taken |=> rsp == '0)
        else $error("Answer fields set without a request");

    // Each value rule refuses the whole write on its own
    chk_legacy_gp: assert property (
        wr_gated && !src[ESE_LEGACY_BIT] |=> rsp.gp && $stable(mask_value))
        else $error("Clearing the legacy bit not refused");

    chk_basic_pair_gp: assert property (
        wr_gated && src[ESE_WIDE_BIT:ESE_BASIC_BIT] == 2'b10
        |=> rsp.gp && $stable(mask_value))
        else $error("Wide without basic state not refused");

    chk_bounds_pair_gp: assert property (
        wr_gated && (src[ESE_BOUNDS_HI] != src[ESE_BOUNDS_LO])
        |=> rsp.gp && $stable(mask_value))
        else $error("Split bounds field not refused");

    chk_ext_field_gp: assert property (
        wr_gated && (src[ESE_EXT_HI:ESE_EXT_LO] != 3'b000)
        && !(&{src[ESE_EXT_HI:ESE_EXT_LO], src[ESE_WIDE_BIT:ESE_BASIC_BIT]})
        |=> rsp.gp && $stable(mask_value))
        else $error("Partial extended vector field not refused");

    chk_tile_pair_gp: assert property (
        wr_gated && (src[ESE_TILE_CFG_BIT] != src[ESE_TILE_DATA_BIT])
        |=> rsp.gp && $stable(mask_value))
        else $error("Split tile field not refused");

    chk_rsvd_gp: assert property (
        wr_gated && ((src & ESE_RSVD_BITS) != 64'h0000_0000_0000_0000)
        |=> rsp.gp && $stable(mask_value))
        else $error("Reserved bit write not refused");

    chk_sel_refused: assert property (
        req.valid && (req.op == ESE_OP_WR_XCR || req.op == ESE_OP_RD_XCR)
        && flag && !sel0 |=> rsp.gp && !rsp.ud && $stable(mask_value))
        else $error("Non-zero selector not refused");

    // Family gates use the registered gate of the request cycle
    chk_wide_gate: assert property (
        fam.wide_vec_ok == (fam.save_feature_enable_flag
        && mask_value[ESE_WIDE_BIT]))
        else $error("Wide vector gate mismatch");

    chk_wide_ud: assert property (
        req.valid && req.op == ESE_OP_WIDE_VEC
        |=> rsp.ud == !$past(fam.wide_vec_ok))
        else $error("Wide vector gating wrong");

    chk_ext_ud: assert property (
        req.valid && req.op == ESE_OP_EXT_VEC
        |=> rsp.ud == !$past(fam.ext_vec_ok))
        else $error("Extended vector gating wrong");

    chk_free_ops: assert property (
        req.valid && (req.op == ESE_OP_BASIC || req.op == ESE_OP_PKEY)
        |=> rsp.valid && !rsp.ud && !rsp.gp)
        else $error("Ungated instruction faulted");

    chk_save_gate: assert property (
        req.valid && req.op == ESE_OP_SAVE_RST
        |=> rsp.ud == !$past(flag))
        else $error("Save or restore gating wrong");

    // Control register four holds only the enable flag
    chk_rd_ctrl_data: assert property (
        req.valid && req.op == ESE_OP_RD_CTRL4 && ring0
        |=> !rsp.gp && rsp.data[ESE_FLAG_BIT] == $past(flag))
        else $error("Control read result wrong");

    chk_flag_load: assert property (
        req.valid && req.op == ESE_OP_WR_CTRL4 && ring0
        |=> fam.save_feature_enable_flag
            == ($past(src[ESE_FLAG_BIT]) && SAVE_SUPPORTED))
        else $error("Enable flag write wrong");

    cov_mask_load: cover property (
        req.valid && req.op == ESE_OP_WR_XCR ##1 rsp.valid && !rsp.gp
        && !rsp.ud);
    cov_mask_fault: cover property (
        req.valid && req.op == ESE_OP_WR_XCR && flag ##1 rsp.gp);
    cov_tile_run: cover property (
        req.valid && req.op == ESE_OP_TILE ##1 rsp.valid && !rsp.ud);
    cov_flag_off: cover property (
        fam.save_feature_enable_flag ##1 !fam.save_feature_enable_flag);
    cov_ext_run: cover property (
        req.valid && req.op == ESE_OP_EXT_VEC ##1 rsp.valid && !rsp.ud);

endmodule : ese_ctrl

// >>> pkg/ese_pkg.sv
// Purpose: Constants and carrier types for extended-state enable control
// Assumes: Single core clock, pipeline sends one control access at a time
// Notes:   Bit positions, op codes and carrier types below are shared by core and bench
package ese_pkg;

    localparam int          ESE_FLAG_BIT      = 18;
    localparam int          ESE_ID_FLAG_BIT   = 27;
    localparam int          ESE_ID_SUPP_BIT   = 26;
    localparam logic [63:0] ESE_MASK_RESET    = 64'h0000_0000_0000_0001;
    localparam logic [63:0] ESE_RSVD_BITS     = 64'hFFFF_FFFF_FFF9_FD00;
    localparam logic [63:0] ESE_CAP_DEFAULT   = 64'h0000_0000_0006_02FF;
    localparam int          ESE_LEGACY_BIT    = 0;
    localparam int          ESE_BASIC_BIT     = 1;
    localparam int          ESE_WIDE_BIT      = 2;
    localparam int          ESE_BOUNDS_LO     = 3;
    localparam int          ESE_BOUNDS_HI     = 4;
    localparam int          ESE_EXT_LO        = 5;
    localparam int          ESE_EXT_HI        = 7;
    localparam int          ESE_TILE_CFG_BIT  = 17;
    localparam int          ESE_TILE_DATA_BIT = 18;
    localparam logic [31:0] ESE_SEL_MASK      = 32'h0000_0000;

    // Control access kinds issued by the pipeline
    typedef enum logic [3:0]
    {
        ESE_OP_NONE     = 4'h0,
        ESE_OP_WR_CTRL4 = 4'h1,
        ESE_OP_RD_CTRL4 = 4'h2,
        ESE_OP_WR_XCR   = 4'h3,
        ESE_OP_RD_XCR   = 4'h4,
        ESE_OP_SAVE_RST = 4'h5,
        ESE_OP_IDENT1   = 4'h6,
        ESE_OP_WIDE_VEC = 4'h7,
        ESE_OP_EXT_VEC  = 4'h8,
        ESE_OP_TILE     = 4'h9,
        ESE_OP_BOUNDS   = 4'hA,
        ESE_OP_BASIC    = 4'hB,
        ESE_OP_PKEY     = 4'hC
    } ese_op_type;

    typedef struct packed
    {
        logic        valid;
        ese_op_type  op;
        logic [1:0]  priv_lvl;
        logic        long_mode;
        logic [31:0] selector;
        logic [31:0] low_src;
        logic [31:0] high_src;
    } ese_req_type;

    typedef struct packed
    {
        logic        valid;
        logic        ud;
        logic        gp;
        logic        nop;
        logic [63:0] data;
    } ese_rsp_type;

    typedef struct packed
    {
        logic save_feature_enable_flag;
        logic wide_vec_ok;
        logic ext_vec_ok;
        logic tile_ok;
        logic bounds_active;
    } ese_family_type;

endpackage : ese_pkg

// >>> testbench/ese_pipe_model.sv
// Purpose: Pipeline stand-in that issues control accesses
// Assumes: Bench hands over one command per cycle on cmd
// Notes:   Idle cycles carry inverted fields, back to the stale ones every second idle cycle
`timescale 1ns/10ps
module ese_pipe_model
    import ese_pkg::*;
(
    input  wire logic        clk,
    input  wire ese_req_type cmd,
    output ese_req_type      req
);
    // Idle fields invert each cycle so the core cannot lean on them
    initial req = '0;
    always @(posedge clk)
    begin
        if (cmd.valid)
            req <= cmd;
        else
            req <= {1'b0, ~req[$bits(req)-2:0]};
    end
endmodule : ese_pipe_model

// >>> testbench/tb_ext_state_enable_control.sv
// Purpose: Self-checking bench for the extended-state enable control
// Assumes: Default capability map and save support on the core
// Notes:   Reference model tracks flag and mask, checked every answer
`timescale 1ns/10ps
module tb_ext_state_enable_control
    import ese_pkg::*;
;
    logic           clk;
    logic           sys_rst;
    ese_req_type    cmd;
    ese_req_type    req;
    ese_rsp_type    rsp;
    ese_family_type fam;
    logic [63:0]    mask_value;
    int             n_mismatch;
    int             checked;
    int             seed;
    logic           m_flag;
    logic [63:0]    m_mask;
    logic [63:0]    bad_v [9] = '{64'h2, 64'h5, 64'hB, 64'h23, 64'hE1,
        64'h2_0003, 64'h103, 64'h1_0000_0003, 64'h8_0003};

    ese_pipe_model pipe (.clk(clk), .cmd(cmd), .req(req));
    ese_ctrl dut (.clk(clk), .sys_rst(sys_rst), .req(req), .rsp(rsp),
        .fam(fam), .mask_value(mask_value));

    // Free-running core clock
    initial
    begin
        clk = 0;
        forever #20 clk = ~clk;
    end

    task automatic chk(input string what, input logic [63:0] seen,
                       input logic [63:0] exp);
        checked++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic chk_state();
        chk("mask", mask_value, m_mask);
        chk("fam", 64'(fam), {59'h0, m_flag, m_flag & m_mask[2],
            m_flag & (&m_mask[7:5]), m_flag & (&m_mask[18:17]),
            m_flag & (&m_mask[4:3])});
    endtask : chk_state

    // Predict from pre-request state, issue, then compare the answer
    task automatic run(input ese_op_type op, input logic [1:0] priv,
                       input logic lm, input logic [31:0] sel,
                       input logic [63:0] s);
        logic        ud;
        logic        gp;
        logic        nop;
        logic        bad;
        logic [63:0] d;
        int          w;
        ud = 0;
        gp = 0;
        nop = 0;
        d = '0;
        bad = !s[0] || s[2:1] == 2'b10 || s[4] != s[3]
            || (s[7:5] != 0 && !(&{s[2:1], s[7:5]}))
            || s[17] != s[18] || |(s & ESE_RSVD_BITS);
        case (op)
            ESE_OP_WR_XCR, ESE_OP_RD_XCR, ESE_OP_SAVE_RST: ud = !m_flag;
            ESE_OP_WIDE_VEC: ud = !(m_flag && m_mask[2]);
            ESE_OP_EXT_VEC: ud = !(m_flag && &m_mask[7:5]);
            ESE_OP_TILE: ud = !(m_flag && &m_mask[18:17] && lm);
            ESE_OP_BOUNDS: nop = !(m_flag && &m_mask[4:3]);
            ESE_OP_IDENT1: d = {36'h0, m_flag, 1'b1, 26'h0};
            ESE_OP_WR_CTRL4, ESE_OP_RD_CTRL4: gp = priv != 0;
            default: ud = 0;
        endcase
        if (op == ESE_OP_WR_XCR || op == ESE_OP_RD_XCR)
            gp = !ud && (sel != 0
                || (op == ESE_OP_WR_XCR && (priv != 0 || bad)));
        if (op == ESE_OP_RD_CTRL4 && !gp)
            d[18] = m_flag;
        if (op == ESE_OP_RD_XCR && !ud && !gp)
            d = m_mask;
        if (op == ESE_OP_WR_CTRL4 && !gp)
            m_flag = s[18];
        if (op == ESE_OP_WR_XCR && !ud && !gp)
            m_mask = s;
        @(posedge clk);
        cmd <= '{1'b1, op, priv, lm, sel, s[31:0], s[63:32]};
        @(posedge clk);
        cmd <= '0;
        w = 0;
        do
        begin
            @(posedge clk);
            #1;
            w++;
        end while (rsp.valid !== 1'b1 && w < 4);
        chk("latency", 64'(w), 64'h1);
        chk("faults", {61'h0, rsp.ud, rsp.gp, rsp.nop},
            {61'h0, ud, gp, nop});
        chk("data", rsp.data, d);
        chk_state();
    endtask : run

    task automatic summarize();
        $display("checked %0d n_mismatch %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : summarize

    // Cut a hang short well past the expected run length
    initial
    begin
        repeat (5000) @(posedge clk);
        n_mismatch++;
        summarize();
    end

    // Main sequence: directed cases, then seeded random traffic
    initial
    begin
        logic [31:0] r;
        logic [31:0] r2;
        sys_rst = 1;
        cmd = '0;
        seed = 32;
        n_mismatch = 0;
        checked = 0;
        m_flag = 0;
        m_mask = 64'h1;
        repeat (3) @(posedge clk);
        sys_rst <= 0;
        @(posedge clk);
        #1;
        chk_state();
        for (int i = 1; i <= 12; i++)
            run(ese_op_type'(i), 0, 1, 0, 64'h1);
        run(ESE_OP_RD_CTRL4, 3, 1, 0, 0);
        run(ESE_OP_WR_CTRL4, 0, 1, 0, 64'h4_0000);
        run(ESE_OP_RD_CTRL4, 0, 1, 0, 0);
        run(ESE_OP_IDENT1, 3, 1, 0, 0);
        run(ESE_OP_WR_XCR, 2, 1, 0, 64'h3);
        run(ESE_OP_WR_XCR, 0, 1, 1, 64'h3);
        run(ESE_OP_WR_XCR, 0, 1, 0, 64'h3);
        // Each illegal pattern refused whole, mask kept
        foreach (bad_v[i])
            run(ESE_OP_WR_XCR, 0, 1, 0, bad_v[i]);
        run(ESE_OP_WR_XCR, 0, 1, 0, 64'h6_02FF);
        for (int i = 5; i <= 12; i++)
            run(ese_op_type'(i), 0, 1, 0, 0);
        run(ESE_OP_TILE, 0, 0, 0, 0);
        run(ESE_OP_RD_XCR, 3, 0, 0, 0);
        run(ESE_OP_RD_XCR, 0, 1, 2, 0);
        run(ESE_OP_WR_XCR, 0, 1, 0, 64'h1);
        repeat (80)
        begin
            r = $random(seed);
            r2 = $random(seed);
            run(ese_op_type'(4'(1 + r[7:0] % 12)), r[9:8] & {2{r[10]}},
                r[11], {31'h0, r[15:12] == 4'hF},
                {r[17:16] == 2'b11 ? r2 : 32'h0, $random(seed) & 32'h6_02FF});
        end
        // Second reset after the random traffic restores reset values
        @(posedge clk);
        sys_rst <= 1;
        repeat (3) @(posedge clk);
        sys_rst <= 0;
        @(posedge clk);
        #1;
        m_flag = 0;
        m_mask = 64'h1;
        chk_state();
        summarize();
    end
endmodule : tb_ext_state_enable_control
